//--- hw/scvr_pkg.sv
// package: constants, register map and types of the two-wire configuration slave
// Function
// - answer only slave addresses 1000100 or 1000110; eighth bit gives direction
// - direction bit 0 means write, 1 means read
// - slave pulls acknowledge low after address, subaddress and each accepted byte
// - pointer increments after each data byte so bytes fill consecutive registers
// - first wide-screen register bits 7..4 give the enhanced-services field
// - first wide-screen register bits 3..0 give the aspect-ratio field
// - second wide-screen register: bits 2..0 subtitles, bits 5..3 reserved field
// - second wide-screen register bit 7 enables wide-screen output, reset 0
// - burst-start bit 7 uses real-time colour detect bit, needs real-time enable
// - burst-start bit 6 picks field sequence from real-time input when enabled
// - six-bit burst start position, reset 21h
// - six-bit burst end position, reset 1dh
// - first copy-generation byte sent lsb first right after run-in
// - second copy-generation byte follows the first, msb carries checksum bit
package scvr_pkg;

	// slave addresses, seven bits without the direction bit
	localparam logic [6:0] SLV_ADDR_A = 7'h44;
	localparam logic [6:0] SLV_ADDR_B = 7'h46;

	// register map
	localparam int REG_COUNT = 6;
	localparam logic [7:0] REG_BASE = 8'h26;
	localparam logic [7:0] OFS_WIDESCREEN_PAYLOAD_LOW = 8'h26;
	localparam logic [7:0] OFS_WIDESCREEN_PAYLOAD_HIGH_ENABLE = 8'h27;
	localparam logic [7:0] OFS_BURST_START = 8'h28;
	localparam logic [7:0] OFS_BURST_END = 8'h29;
	localparam logic [7:0] OFS_COPY_GENERATION_BYTE0 = 8'h2a;
	localparam logic [7:0] OFS_COPY_GENERATION_BYTE1 = 8'h2b;

	// reset values, index 0 is the register at REG_BASE
	localparam logic [7:0] RST_WIDESCREEN_PAYLOAD_LOW = 8'h00;
	localparam logic [7:0] RST_WIDESCREEN_PAYLOAD_HIGH_ENABLE = 8'h00;
	localparam logic [7:0] RST_BURST_START = 8'h21;
	localparam logic [7:0] RST_BURST_END = 8'h1d;
	localparam logic [7:0] RST_COPY_GENERATION_BYTE0 = 8'h00;
	localparam logic [7:0] RST_COPY_GENERATION_BYTE1 = 8'h00;
	localparam logic [REG_COUNT-1:0][7:0] REG_RST = {RST_COPY_GENERATION_BYTE1,
		RST_COPY_GENERATION_BYTE0, RST_BURST_END, RST_BURST_START,
		RST_WIDESCREEN_PAYLOAD_HIGH_ENABLE, RST_WIDESCREEN_PAYLOAD_LOW};

	// writable bits; reserved bits are held at zero
	localparam logic [REG_COUNT-1:0][7:0] REG_WMASK = {8'hff, 8'hff, 8'h3f, 8'hff, 8'hbf, 8'hff};

	// field positions
	localparam int WIDESCREEN_OUTPUT_ON_BIT = 7;
	localparam int COLOUR_DETECT_SEL_BIT = 7;
	localparam int FIELD_SEQ_SEL_BIT = 6;

	// configuration carried out of the register file
	typedef struct packed {
		logic [13:0] widescreen_bits;
		logic widescreen_output_on;
		logic colour_detect_from_rt_input;
		logic field_seq_from_rt_input;
		logic [5:0] burst_start_pos;
		logic [5:0] burst_end_pos;
		logic [15:0] copy_gen_code;
	} scvr_cfg_t;

	// serial slave states
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_ADDR_ACK = 9'h004,
		ST_SUB = 9'h008,
		ST_SUB_ACK = 9'h010,
		ST_WDATA = 9'h020,
		ST_WDATA_ACK = 9'h040,
		ST_RDATA = 9'h080,
		ST_RDATA_ACK = 9'h100
	} scvr_state_t;

endpackage

//--- hw/scvr_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module scvr_sync #(
	parameter int WIDTH = 2
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// resets high: an idle two-wire bus floats high, so no false start after reset
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_q <= '1;
			sync_out <= '1;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

//--- hw/scvr_cg_ser.sv
// copy-generation serialiser: two bytes, lsb first, byte 0 then byte 1
`timescale 1ns/1ns
module scvr_cpy_ser (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic line_start,
	input wire logic bit_en,
	input wire logic [15:0] code,
	output logic bit_q,
	output logic valid_q
);

	logic [15:0] shift_q;
	logic [4:0] cnt_q;
	logic [15:0] snap_q;
	wire emit = bit_en && (cnt_q != 5'h00);

	// code is captured at line start so a register write mid-line cannot tear it
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			shift_q <= 16'h0000;
			cnt_q <= 5'h00;
			bit_q <= 1'b0;
			valid_q <= 1'b0;
		end else if (line_start) begin
			shift_q <= code;
			cnt_q <= 5'h10;
			valid_q <= 1'b0;
		end else if (emit) begin
			bit_q <= shift_q[0];
			shift_q <= {1'b0, shift_q[15:1]};
			cnt_q <= cnt_q - 5'h01;
			valid_q <= 1'b1;
		end else if (bit_en) begin
			valid_q <= 1'b0;
		end
	end

	// helper copy of the loaded code, read only by the check below
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			snap_q <= 16'h0000;
		end else if (line_start) begin
			snap_q <= code;
		end
	end

	cpy_order_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(emit && !line_start) |=> (valid_q && bit_q == snap_q[4'(5'h10 - $past(cnt_q))]))
		else $error("copy generation bit out of order");

endmodule

//--- hw/scvr_top.sv
// two-wire configuration slave with wide-screen, burst and copy-generation registers
`timescale 1ns/1ns
module scvr_top #(
	parameter int CPY_BIT_DIV = 64
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic field_sequence_select,
	input wire logic realtime_control_enable,
	input wire logic rt_field_seq,
	input wire logic rt_colour_detect,
	input wire logic cpy_line_start,
	output scvr_pkg::scvr_cfg_t cfg,
	output logic field_seq_q,
	output logic colour_detect_q,
	output logic cpy_bit,
	output logic cpy_bit_valid
);

	logic [1:0] pin_s;
	logic scl_prev_q;
	logic sda_prev_q;
	scvr_pkg::scvr_state_t state_q;
	scvr_pkg::scvr_state_t state_d;
	logic [3:0] bitcnt_q;
	logic [3:0] bitcnt_d;
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic [7:0] ptr_q;
	logic [7:0] ptr_d;
	logic sda_oe_q;
	logic sda_oe_d;
	logic rw_q;
	logic rw_d;
	logic mack_q;
	logic mack_d;
	logic [7:0] regs_q [scvr_pkg::REG_COUNT];
	logic [15:0] div_q;

	// pins pass two flops before any edge logic looks at them
	scvr_sync #(
		.WIDTH(2)
	) u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.async_in({scl_i, sda_i}),
		.sync_out(pin_s)
	);

	wire scl_s = pin_s[1];
	wire sda_s = pin_s[0];

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	// bus events; start and stop are sda edges while scl stays high
	wire scl_rise = scl_s && !scl_prev_q;
	wire scl_fall = !scl_s && scl_prev_q;
	wire start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
	wire stop_det = scl_s && scl_prev_q && !sda_prev_q && sda_s;
	wire byte_done = (bitcnt_q == 4'h8);
	wire addr_match = (shift_q[7:1] == scvr_pkg::SLV_ADDR_A) || (shift_q[7:1] == scvr_pkg::SLV_ADDR_B);

	// register decode for the current and the next pointer
	wire [7:0] rel_cur = ptr_q - scvr_pkg::REG_BASE;
	wire [7:0] ptr_inc = ptr_q + 8'h01;
	wire [7:0] rel_next = ptr_inc - scvr_pkg::REG_BASE;
	wire cur_hit = rel_cur < 8'(scvr_pkg::REG_COUNT);
	wire next_hit = rel_next < 8'(scvr_pkg::REG_COUNT);
	wire [7:0] rd_byte = cur_hit ? regs_q[rel_cur[2:0]] : 8'h00;
	wire [7:0] rd_next = next_hit ? regs_q[rel_next[2:0]] : 8'h00;
	wire wr_en = scl_fall && !start_det && !stop_det && (state_q == scvr_pkg::ST_WDATA) && byte_done;

	// slave sequencer; data moves on scl falling edges, samples taken on rising
	always_comb begin
		state_d = state_q;
		bitcnt_d = bitcnt_q;
		shift_d = shift_q;
		ptr_d = ptr_q;
		sda_oe_d = sda_oe_q;
		rw_d = rw_q;
		mack_d = mack_q;
		if (stop_det) begin
			state_d = scvr_pkg::ST_IDLE;
			sda_oe_d = 1'b0;
		end else if (start_det) begin
			state_d = scvr_pkg::ST_ADDR;
			bitcnt_d = 4'h0;
			sda_oe_d = 1'b0;
		end else if (scl_rise) begin
			if (state_q == scvr_pkg::ST_ADDR || state_q == scvr_pkg::ST_SUB || state_q == scvr_pkg::ST_WDATA) begin
				shift_d = {shift_q[6:0], sda_s};
				bitcnt_d = bitcnt_q + 4'h1;
			end
			if (state_q == scvr_pkg::ST_RDATA_ACK) begin
				mack_d = !sda_s;
			end
		end else if (scl_fall) begin
			unique case (state_q)
				scvr_pkg::ST_IDLE: begin
					state_d = scvr_pkg::ST_IDLE;
				end
				scvr_pkg::ST_ADDR: begin
					if (byte_done && addr_match) begin
						state_d = scvr_pkg::ST_ADDR_ACK;
						sda_oe_d = 1'b1;
						rw_d = shift_q[0];
					end else if (byte_done) begin
						state_d = scvr_pkg::ST_IDLE;
					end
				end
				scvr_pkg::ST_ADDR_ACK: begin
					bitcnt_d = 4'h0;
					if (rw_q) begin
						state_d = scvr_pkg::ST_RDATA;
						shift_d = rd_byte;
						sda_oe_d = !rd_byte[7];
					end else begin
						state_d = scvr_pkg::ST_SUB;
						sda_oe_d = 1'b0;
					end
				end
				scvr_pkg::ST_SUB: begin
					if (byte_done) begin
						state_d = scvr_pkg::ST_SUB_ACK;
						sda_oe_d = 1'b1;
					end
				end
				scvr_pkg::ST_SUB_ACK: begin
					ptr_d = shift_q;
					state_d = scvr_pkg::ST_WDATA;
					sda_oe_d = 1'b0;
					bitcnt_d = 4'h0;
				end
				scvr_pkg::ST_WDATA: begin
					if (byte_done) begin
						state_d = scvr_pkg::ST_WDATA_ACK;
						sda_oe_d = 1'b1;
					end
				end
				scvr_pkg::ST_WDATA_ACK: begin
					ptr_d = ptr_inc;
					state_d = scvr_pkg::ST_WDATA;
					sda_oe_d = 1'b0;
					bitcnt_d = 4'h0;
				end
				scvr_pkg::ST_RDATA: begin
					if (bitcnt_q == 4'h7) begin
						state_d = scvr_pkg::ST_RDATA_ACK;
						sda_oe_d = 1'b0;
						mack_d = 1'b0;
					end else begin
						shift_d = {shift_q[6:0], 1'b0};
						sda_oe_d = !shift_q[6];
						bitcnt_d = bitcnt_q + 4'h1;
					end
				end
				scvr_pkg::ST_RDATA_ACK: begin
					if (mack_q) begin
						ptr_d = ptr_inc;
						shift_d = rd_next;
						sda_oe_d = !rd_next[7];
						bitcnt_d = 4'h0;
						state_d = scvr_pkg::ST_RDATA;
					end else begin
						state_d = scvr_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= scvr_pkg::ST_IDLE;
			bitcnt_q <= 4'h0;
			shift_q <= 8'h00;
			ptr_q <= 8'h00;
			sda_oe_q <= 1'b0;
			rw_q <= 1'b0;
			mack_q <= 1'b0;
		end else begin
			state_q <= state_d;
			bitcnt_q <= bitcnt_d;
			shift_q <= shift_d;
			ptr_q <= ptr_d;
			sda_oe_q <= sda_oe_d;
			rw_q <= rw_d;
			mack_q <= mack_d;
		end
	end

	// open drain: only ever pull low
	assign sda_o = 1'b0;
	assign sda_oe = sda_oe_q;

	// register file; unmapped subaddresses are acknowledged but store nothing
	for (genvar i = 0; i < scvr_pkg::REG_COUNT; i++) begin : g_reg
		always_ff @(posedge sys_clk or posedge sys_rst) begin
			if (sys_rst) begin
				regs_q[i] <= scvr_pkg::REG_RST[i];
			end else if (wr_en && cur_hit && rel_cur[2:0] == 3'(i)) begin
				regs_q[i] <= shift_q & scvr_pkg::REG_WMASK[i];
			end
		end
	end

	// configuration fields taken straight from the register flops
	assign cfg.widescreen_bits = {regs_q[1][5:0], regs_q[0][7:4], regs_q[0][3:0]};
	assign cfg.widescreen_output_on = regs_q[1][scvr_pkg::WIDESCREEN_OUTPUT_ON_BIT];
	assign cfg.colour_detect_from_rt_input = regs_q[2][scvr_pkg::COLOUR_DETECT_SEL_BIT];
	assign cfg.field_seq_from_rt_input = regs_q[2][scvr_pkg::FIELD_SEQ_SEL_BIT];
	assign cfg.burst_start_pos = regs_q[2][5:0];
	assign cfg.burst_end_pos = regs_q[3][5:0];
	assign cfg.copy_gen_code = {regs_q[5], regs_q[4]};

	// real-time input options only take hold when the real-time enable is set
	wire field_src_rt = cfg.field_seq_from_rt_input && realtime_control_enable;
	wire col_src_rt = cfg.colour_detect_from_rt_input && realtime_control_enable;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			field_seq_q <= 1'b0;
			colour_detect_q <= 1'b1;
		end else begin
			field_seq_q <= field_src_rt ? rt_field_seq : field_sequence_select;
			colour_detect_q <= col_src_rt ? rt_colour_detect : 1'b1;
		end
	end

	// copy-generation bit clock; restarts at each line so the first bit lands at a fixed place
	wire cpy_bit_en = (div_q == 16'(CPY_BIT_DIV - 1));

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_q <= 16'h0000;
		end else if (cpy_line_start || cpy_bit_en) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	scvr_cpy_ser u_cpy_ser (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.line_start(cpy_line_start),
		.bit_en(cpy_bit_en),
		.code(cfg.copy_gen_code),
		.bit_q(cpy_bit),
		.valid_q(cpy_bit_valid)
	);

	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_byte_end(scvr_pkg::scvr_state_t st);
		scl_fall && !start_det && !stop_det && state_q == st && byte_done;
	endsequence

	sequence s_ack_end(scvr_pkg::scvr_state_t st);
		scl_fall && !start_det && !stop_det && state_q == st;
	endsequence

	addr_reject_a: assert property (s_byte_end(scvr_pkg::ST_ADDR) and (!addr_match)
		|=> state_q == scvr_pkg::ST_IDLE && !sda_oe)
		else $error("foreign address not ignored");
	addr_ack_a: assert property (s_byte_end(scvr_pkg::ST_ADDR) and addr_match
		|=> sda_oe && state_q == scvr_pkg::ST_ADDR_ACK)
		else $error("own address not acknowledged");
	rw_dir_a: assert property (s_ack_end(scvr_pkg::ST_ADDR_ACK)
		|=> state_q == (rw_q ? scvr_pkg::ST_RDATA : scvr_pkg::ST_SUB))
		else $error("direction bit not obeyed");
	data_ack_a: assert property (s_byte_end(scvr_pkg::ST_WDATA) |=> sda_oe ##1 sda_oe)
		else $error("data byte not acknowledged");
	ptr_step_a: assert property (s_ack_end(scvr_pkg::ST_WDATA_ACK) |=> ptr_q == $past(ptr_q) + 8'h01)
		else $error("pointer did not advance");
	wide_on_store_a: assert property ((wr_en && ptr_q == scvr_pkg::OFS_WIDESCREEN_PAYLOAD_HIGH_ENABLE)
		|=> cfg.widescreen_output_on == $past(shift_q[7]) && !regs_q[1][6])
		else $error("wide-screen enable not stored");
	burst_store_a: assert property ((wr_en && ptr_q == scvr_pkg::OFS_BURST_START)
		|=> cfg.burst_start_pos == $past(shift_q[5:0]))
		else $error("burst start not stored");
	read_first_a: assert property ((s_ack_end(scvr_pkg::ST_ADDR_ACK) and rw_q)
		|=> sda_oe == !$past(rd_byte[7]))
		else $error("read returns wrong register");
	field_gate_a: assert property (!realtime_control_enable |=> field_seq_q == $past(field_sequence_select))
		else $error("field sequence taken from real-time input while disabled");
	colour_gate_a: assert property ((!realtime_control_enable || !cfg.colour_detect_from_rt_input)
		|=> colour_detect_q)
		else $error("colour detect used while disabled");

endmodule

//--- bench/scvr_master.sv
// two-wire bus master model: serial clock and open-drain data
`timescale 1ns/1ns
module scvr_master #(
	parameter int HALF = 10
) (
	input wire logic sys_clk,
	output logic scl,
	output logic sda_pull,
	input wire logic sda
);
	// bus idle: clock high, data released to the pull-up
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// start, also a repeated start from a low clock
	task automatic start();
		tick(2);
		sda_pull = 1'b0;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		sda_pull = 1'b1;
		tick(HALF);
		scl = 1'b0;
	endtask

	task automatic stop();
		tick(2);
		sda_pull = 1'b1;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		sda_pull = 1'b0;
		tick(HALF);
	endtask

	// data moves two cycles after the clock fall so it never looks like start or stop
	task automatic bit_io(input logic tx, output logic rx);
		tick(2);
		sda_pull = ~tx;
		tick(HALF - 2);
		scl = 1'b1;
		tick(HALF);
		rx = sda;
		scl = 1'b0;
	endtask

	// msb first, then the acknowledge slot; ack is 1 when the slot was low
	task automatic byte_io(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], b);
			rx[i] = b;
		end
		bit_io(~mack, b);
		ack = ~b;
	endtask

	// address with write bit, subaddress, data, stop
	task automatic wr(input logic [6:0] dev, input logic [7:0] sub, input logic [7:0] d[$], output logic acks);
		logic [7:0] r;
		logic a;
		start();
		byte_io({dev, 1'b0}, 1'b0, r, acks);
		if (acks) begin
			byte_io(sub, 1'b0, r, a);
			acks = acks & a;
			foreach (d[i]) begin
				byte_io(d[i], 1'b0, r, a);
				acks = acks & a;
			end
		end
		stop();
	endtask

	// pointer set by a subaddress write, repeated start, read bit; last byte not acked
	task automatic rd(input logic [6:0] dev, input logic [7:0] sub, input int n, output logic [7:0] d[$],
		output logic acks);
		logic [7:0] r;
		logic a;
		d = {};
		start();
		byte_io({dev, 1'b0}, 1'b0, r, acks);
		byte_io(sub, 1'b0, r, a);
		acks = acks & a;
		start();
		byte_io({dev, 1'b1}, 1'b0, r, a);
		acks = acks & a;
		for (int i = 0; i < n; i++) begin
			byte_io(8'hff, i < n - 1, r, a);
			d.push_back(r);
		end
		stop();
	endtask
endmodule

//--- bench/scvr_top_tb.sv
// self-checking bench for the two-wire configuration slave
`timescale 1ns/1ns
module scvr_top_tb;
	localparam int CPY_DIV = 4;
	logic sys_clk, sys_rst, scl, sda_pull, sda, sda_o, sda_oe;
	logic fss, rte, rt_fs, rt_cd, cpy_start, field_seq_q, colour_detect_q, cpy_bit, cpy_bit_valid;
	scvr_pkg::scvr_cfg_t cfg;
	int num_errors = 0;
	int num_checks = 0;
	logic [7:0] rst_exp[$] = '{8'h00, 8'h00, 8'h21, 8'h1d, 8'h00, 8'h00};
	// reserved bits of 27h and 29h written as 0
	logic [7:0] wdata[$] = '{8'ha5, 8'had, 8'hc3, 8'h3e, 8'h5a, 8'hc6};

	// open-drain wire with pull-up
	assign sda = ~(sda_pull | sda_oe);

	scvr_top #(.CPY_BIT_DIV(CPY_DIV)) i_scvr_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .field_sequence_select(fss), .realtime_control_enable(rte),
		.rt_field_seq(rt_fs), .rt_colour_detect(rt_cd), .cpy_line_start(cpy_start), .cfg(cfg),
		.field_seq_q(field_seq_q), .colour_detect_q(colour_detect_q), .cpy_bit(cpy_bit),
		.cpy_bit_valid(cpy_bit_valid));

	scvr_master i_scvr_master (.sys_clk(sys_clk), .scl(scl), .sda_pull(sda_pull), .sda(sda));

	always #4 sys_clk = ~sys_clk;

	task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic check_bit(input string what, input logic exp, input logic got);
		check_val(what, {15'h0000, exp}, {15'h0000, got});
	endtask

	task automatic test_reset();
		logic [7:0] d[$];
		logic a;
		check_bit("widescreen on", 1'b0, cfg.widescreen_output_on);
		check_val("burst start", 16'h0021, 16'(cfg.burst_start_pos));
		check_val("burst end", 16'h001d, 16'(cfg.burst_end_pos));
		check_bit("colour idle", 1'b1, colour_detect_q);
		check_bit("data out level", 1'b0, sda_o);
		i_scvr_master.rd(7'h44, 8'h26, 6, d, a);
		check_bit("ack", 1'b1, a);
		foreach (rst_exp[i]) check_val("reset read", rst_exp[i], d[i]);
		$display("test_reset done");
	endtask

	// only two of the nearby addresses answer; an unmapped place reads zero
	task automatic test_addr();
		logic [6:0] devs[5] = '{7'h42, 7'h45, 7'h47, 7'h44, 7'h46};
		logic [7:0] q[$];
		logic a;
		for (int i = 0; i < 5; i++) begin
			q = '{8'h10 | 8'(i)};
			i_scvr_master.wr(devs[i], 8'h26, q, a);
			check_bit("addr ack", i >= 3, a);
			check_val("reg26", (i < 3) ? 16'h0000 : 16'h0010 | 16'(i), 16'(cfg.widescreen_bits[7:0]));
		end
		q = '{8'h77};
		i_scvr_master.wr(7'h44, 8'h30, q, a);
		i_scvr_master.rd(7'h44, 8'h30, 1, q, a);
		check_val("unmapped", 16'h0000, 16'(q[0]));
		$display("test_addr done");
	endtask

	task automatic test_burst();
		logic [7:0] d[$];
		logic a;
		i_scvr_master.wr(7'h46, 8'h26, wdata, a);
		check_bit("ack", 1'b1, a);
		check_val("services", 16'h000a, 16'(cfg.widescreen_bits[7:4]));
		check_val("aspect", 16'h0005, 16'(cfg.widescreen_bits[3:0]));
		check_val("upper widescreen", 16'h0005 | 16'h0028, 16'(cfg.widescreen_bits[13:8]));
		check_bit("widescreen on", 1'b1, cfg.widescreen_output_on);
		check_bit("colour sel", 1'b1, cfg.colour_detect_from_rt_input);
		check_bit("field sel", 1'b1, cfg.field_seq_from_rt_input);
		check_val("burst start", 16'h0003, 16'(cfg.burst_start_pos));
		check_val("burst end", 16'h003e, 16'(cfg.burst_end_pos));
		check_val("copy code", 16'hc65a, cfg.copy_gen_code);
		i_scvr_master.rd(7'h46, 8'h26, 6, d, a);
		foreach (wdata[i]) check_val("read back", wdata[i], d[i]);
		$display("test_burst done");
	endtask

	// every mix of enable and real-time bits, one cycle latency
	task automatic test_rt(input logic sel);
		for (int i = 0; i < 8; i++) begin
			@(negedge sys_clk);
			rte = i[0];
			rt_fs = i[1];
			rt_cd = i[2];
			fss = ~i[1];
			@(negedge sys_clk);
			check_bit("field seq", (sel & rte) ? rt_fs : fss, field_seq_q);
			check_bit("colour", (sel & rte) ? rt_cd : 1'b1, colour_detect_q);
		end
		$display("test_rt done");
	endtask

	task automatic test_copy_gen();
		@(negedge sys_clk);
		cpy_start = 1'b1;
		@(negedge sys_clk);
		cpy_start = 1'b0;
		for (int n = 0; n < 4 * CPY_DIV && cpy_bit_valid !== 1'b1; n++) @(negedge sys_clk);
		for (int k = 0; k < 16; k++) begin
			check_bit("copy valid", 1'b1, cpy_bit_valid);
			check_bit("copy bit", wdata[4 + k / 8][k % 8], cpy_bit);
			repeat (CPY_DIV) @(negedge sys_clk);
		end
		check_bit("copy valid end", 1'b0, cpy_bit_valid);
		$display("test_copy_gen done");
	endtask

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// main sequence; inputs change on the falling edge
	initial begin
		logic [7:0] q[$];
		logic a;
		sys_clk = 1'b0;
		sys_rst = 1'b1;
		{fss, rte, rt_fs, rt_cd, cpy_start} = 5'h00;
		repeat (10) @(negedge sys_clk);
		sys_rst = 1'b0;
		repeat (5) @(negedge sys_clk);
		test_reset();
		test_addr();
		test_burst();
		test_rt(1'b1);
		q = '{8'h21};
		i_scvr_master.wr(7'h44, 8'h28, q, a);
		test_rt(1'b0);
		test_copy_gen();
		finish_test();
	end

	// hang guard, about four times the expected run
	initial begin
		repeat (40000) @(posedge sys_clk);
		num_errors++;
		$display("unexpected timeout: expected end of tests, seen none");
		finish_test();
	end
endmodule
